/* core/irq_accept_pkg.sv */
// Shared constants and carrier types for the interrupt acceptance block
// Functional notes
// - A nonmaskable request taken while DMA runs stops the transfer controller.
// - Burst memory-to-memory DMA blocks external maskable and internal requests.
// - Cycle-steal memory-to-memory DMA still lets maskable and internal requests in.
// - The mode 2 vector low bit is passed unchanged, an odd value works too.
// - A nonmaskable request during a maskable acknowledge waits one instruction, not enable or disable.
// - A maskable request during a nonmaskable acknowledge waits one instruction.
// - No acknowledge in refresh; a latched nonmaskable request goes after the next instruction.
// - A maskable line still asserted after refresh is taken after the next instruction.
// - Requests are accepted only at the end of an instruction, never at an enable instruction end.
// - A request around an enable instruction is held and accepted after the next instruction.
// - Vector fetch addresses pass through the address translator.
// - A stopped transfer controller stays stopped until software rewrites its enable bit.
// - Request lines are sampled at the sample point of the last machine cycle.
package irq_accept_pkg;
	localparam int LOG_W      = 16;
	localparam int PHYS_W     = 20;
	localparam int PAGE_LSB   = 12;
	localparam int NIB_W      = 4;
	localparam int BASE_W     = 8;
	localparam int VEC_W      = 8;
	localparam int EXT_N      = 3;
	localparam int INTERNAL_N = 6;

	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_NMI  = 2'b01,
		ACK_INT  = 2'b10
	} ack_state_t;

	typedef struct packed {
		logic sample_point;  // Falling edge before T3/Ti of last cycle
		logic instr_end;     // Last machine cycle ends
		logic enable_irq_instruction;   // Ending instruction enables maskable
		logic disable_irq_instruction;  // Ending instruction disables maskable
		logic ack_done;      // Acknowledge sequence finished
		logic irq_enable;    // Maskable enable flip-flop
		logic vec_mode2;
	} seq_status_t;

	typedef struct packed {
		logic refresh_active;
		logic dma_active;
		logic dma_burst_mm;
		logic dma_enable_write;  // Write to dma_channel_enable_bit
	} bus_status_t;

	typedef struct packed {
		logic [NIB_W-1:0]  bank_start;
		logic [NIB_W-1:0]  common1_start;
		logic [BASE_W-1:0] bank_base;
		logic [BASE_W-1:0] common1_base;
	} xlate_cfg_t;
endpackage

/* core/req_sync.sv */
// Two-stage synchroniser for asynchronous request pins
`timescale 1ns/1ps
`default_nettype none
module req_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in,  // System clock
	input  wire logic         srst_in,     // Sync reset, high
	input  wire logic [W-1:0] async_in,    // Pin levels
	output logic      [W-1:0] sync_out     // Synchronised levels
);
	logic [W-1:0] meta;

	// Reset value is idle-high since the pins are active low
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			meta     <= '1;
			sync_out <= '1;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

/* core/vector_xlate.sv */
// Address translator for interrupt vector fetches
`timescale 1ns/1ps
`default_nettype none
module vector_xlate
	import irq_accept_pkg::*;
(
	input  wire logic              ref_clk_in,  // System clock
	input  wire logic              srst_in,     // Sync reset, high
	input  wire logic              req_in,      // Translate request
	input  wire logic [LOG_W-1:0]  log_in,      // Logical address
	input  wire xlate_cfg_t        cfg_in,      // Current base programming
	output logic                   valid_out,   // Result valid pulse
	output logic      [PHYS_W-1:0] phys_out     // Physical address
);
	generate
		if (PHYS_W < LOG_W)
			$error("vector_xlate: physical width below logical width");
	endgenerate

	function automatic logic [BASE_W-1:0] pick_base(input logic [NIB_W-1:0] pg,
			input xlate_cfg_t c);
		if (pg >= c.common1_start)
			pick_base = c.common1_base;
		else if (pg >= c.bank_start)
			pick_base = c.bank_base;
		else
			pick_base = '0;
	endfunction

	logic [NIB_W-1:0]  page;
	logic [PHYS_W-1:0] next_phys;
	assign page = log_in[LOG_W-1 -: NIB_W];
	// Same translation as any fetch, the low page bits pass untouched
	assign next_phys = PHYS_W'(log_in) + {pick_base(page, cfg_in), PAGE_LSB'(0)};

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			valid_out <= 1'b0;
			phys_out  <= '0;
		end else begin
			valid_out <= req_in;
			if (req_in)
				phys_out <= next_phys;
		end
	end
endmodule
`default_nettype wire

/* core/cpu_interrupt_acceptance.sv */
// Interrupt acceptance for the processor core
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_acceptance
	import irq_accept_pkg::*;
#(
	parameter int EXT_REQ_N = EXT_N,
	parameter int INT_REQ_N = INTERNAL_N
) (
	input  wire logic                             ref_clk_in,       // System clock
	input  wire logic                             srst_in,          // Sync reset, high
	input  wire logic                             nmi_n_in,         // Nonmaskable pin, falling edge
	input  wire logic [EXT_REQ_N-1:0]             ext_req_n_in,     // Maskable pins, low level
	input  wire logic [INT_REQ_N-1:0]             internal_req_in,  // Peripheral requests
	input  wire irq_accept_pkg::seq_status_t      seq_in,           // Instruction sequencer
	input  wire irq_accept_pkg::bus_status_t      bus_in,           // DMA and refresh status
	input  wire logic [irq_accept_pkg::VEC_W-1:0] vector_byte_in,   // Vector from data bus
	input  wire logic [irq_accept_pkg::VEC_W-1:0] vector_page_in,   // Vector table page
	input  wire irq_accept_pkg::xlate_cfg_t       xlate_cfg_in,     // Base register set
	output logic                                  nmi_ack_out,      // Nonmaskable ack running
	output logic                                  int_ack_out,      // Maskable ack running
	output logic                                  dma_stop_out,     // Transfer controller halted
	output logic                                  vector_valid_out, // Vector address pulse
	output logic [irq_accept_pkg::PHYS_W-1:0]     vector_addr_out   // Translated vector
);
	import irq_accept_pkg::*;

	generate
		if (EXT_REQ_N < 1 || INT_REQ_N < 1)
			$error("cpu_interrupt_acceptance: request counts must be at least one");
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic                 nmi_n_sync;
	logic                 nmi_n_prev;
	logic [EXT_REQ_N-1:0] ext_n_sync;

	req_sync #(.W(1)) u_nmi_sync (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.async_in   (nmi_n_in),
		.sync_out   (nmi_n_sync)
	);

	req_sync #(.W(EXT_REQ_N)) u_ext_sync (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.async_in   (ext_req_n_in),
		.sync_out   (ext_n_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Request capture

	ack_state_t state;
	logic       nmi_latch;
	logic       nmi_seen;
	logic       int_seen;
	logic       nmi_fall;
	logic       take_nmi;
	logic       take_int;
	logic       accept_ok;
	logic       refresh_seen;
	logic       gap;
	logic       maskable_raw;

	assign nmi_fall = nmi_n_prev && !nmi_n_sync;
	assign maskable_raw = (|(~ext_n_sync)) || (|internal_req_in);

	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			nmi_n_prev <= 1'b1;
		else
			nmi_n_prev <= nmi_n_sync;
	end

	// Edge latch survives refresh and blocked ends; a new edge beats the clear
	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			nmi_latch <= 1'b0;
		else if (nmi_fall)
			nmi_latch <= 1'b1;
		else if (take_nmi)
			nmi_latch <= 1'b0;
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			nmi_seen <= 1'b0;
			int_seen <= 1'b0;
		end else if (seq_in.sample_point) begin
			nmi_seen <= nmi_latch || nmi_fall;
			// Burst transfer owns the bus, maskable requests go unseen
			int_seen <= maskable_raw && !(bus_in.dma_active && bus_in.dma_burst_mm);
		end else if (take_nmi || take_int) begin
			nmi_seen <= 1'b0;
			int_seen <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acceptance point

	// The instruction holding a refresh cannot end in an acknowledge
	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			refresh_seen <= 1'b0;
		else if (bus_in.refresh_active)
			refresh_seen <= 1'b1;
		else if (seq_in.instr_end)
			refresh_seen <= 1'b0;
	end

	// One full instruction must run after an acknowledge; enable and disable do not count
	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			gap <= 1'b0;
		else if (state != ACK_IDLE && seq_in.ack_done)
			gap <= 1'b1;
		else if (seq_in.instr_end && !seq_in.enable_irq_instruction && !seq_in.disable_irq_instruction)
			gap <= 1'b0;
	end

	always_comb begin
		accept_ok = seq_in.instr_end && state == ACK_IDLE;
		if (seq_in.enable_irq_instruction)
			accept_ok = 1'b0;
		if (gap && seq_in.disable_irq_instruction)
			accept_ok = 1'b0;
		if (refresh_seen || bus_in.refresh_active)
			accept_ok = 1'b0;
	end

	assign take_nmi = accept_ok && nmi_seen;
	assign take_int = accept_ok && !nmi_seen && int_seen && seq_in.irq_enable
		&& !(bus_in.dma_active && bus_in.dma_burst_mm);

	////////////////////////////////////////////////////////////////////////////////
	// Acknowledge sequence

	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			state <= ACK_IDLE;
		else begin
			case (state)
				ACK_IDLE: begin
					if (take_nmi)
						state <= ACK_NMI;
					else if (take_int)
						state <= ACK_INT;
				end
				ACK_NMI, ACK_INT: begin
					if (seq_in.ack_done)
						state <= ACK_IDLE;
				end
				default: state <= ACK_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			nmi_ack_out <= 1'b0;
			int_ack_out <= 1'b0;
		end else begin
			nmi_ack_out <= take_nmi || (state == ACK_NMI && !seq_in.ack_done);
			int_ack_out <= take_int || (state == ACK_INT && !seq_in.ack_done);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer controller stop

	always_ff @(posedge ref_clk_in) begin
		if (srst_in)
			dma_stop_out <= 1'b0;
		else if (take_nmi && bus_in.dma_active)
			dma_stop_out <= 1'b1;
		else if (bus_in.dma_enable_write)
			dma_stop_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Vector address

	logic [LOG_W-1:0]  vec_log;
	logic              vec_req;
	logic              xl_valid;
	logic [PHYS_W-1:0] xl_phys;

	// Low bit kept as supplied: odd table pointers still sequence
	assign vec_log = {vector_page_in, vector_byte_in};
	assign vec_req = take_int && seq_in.vec_mode2;

	vector_xlate u_xlate (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.req_in     (vec_req),
		.log_in     (vec_log),
		.cfg_in     (xlate_cfg_in),
		.valid_out  (xl_valid),
		.phys_out   (xl_phys)
	);

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			vector_valid_out <= 1'b0;
			vector_addr_out  <= '0;
		end else begin
			vector_valid_out <= xl_valid;
			if (xl_valid)
				vector_addr_out <= xl_phys;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_nmi_in_dma;
		take_nmi && bus_in.dma_active;
	endsequence

	sequence s_ack_finish;
		state != ACK_IDLE && seq_in.ack_done;
	endsequence

	chk_dma_stop_nmi: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		s_nmi_in_dma |=> dma_stop_out)
		else $error("transfer not stopped by nonmaskable accept");

	chk_burst_blocks_int: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(bus_in.dma_active && bus_in.dma_burst_mm) |-> !take_int)
		else $error("maskable accepted during burst transfer");

	chk_steal_accepts: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(accept_ok && int_seen && !nmi_seen && seq_in.irq_enable && bus_in.dma_active
		&& !bus_in.dma_burst_mm) |=> int_ack_out)
		else $error("maskable refused during cycle steal");

	chk_vector_low_bit: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		vec_req |-> ##2 (vector_valid_out && vector_addr_out[0] == $past(vector_byte_in[0], 2)))
		else $error("vector low bit altered");

	chk_gap_after_ack: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(gap && seq_in.instr_end && seq_in.disable_irq_instruction) |-> !take_nmi && !take_int)
		else $error("acknowledge without an instruction between");

	chk_refresh_quiet: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(bus_in.refresh_active || refresh_seen) |-> !(take_nmi || take_int))
		else $error("acknowledge inside refresh instruction");

	chk_nmi_held: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(nmi_latch && !take_nmi) |=> nmi_latch)
		else $error("latched nonmaskable request lost");

	chk_final_cycle: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		($rose(nmi_ack_out) || $rose(int_ack_out))
		|-> $past(seq_in.instr_end) && !$past(seq_in.enable_irq_instruction))
		else $error("accept outside final cycle or at enable instruction end");

	chk_stop_holds: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(dma_stop_out && !bus_in.dma_enable_write) |=> dma_stop_out)
		else $error("transfer stop released without enable write");

	chk_nmi_first: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(accept_ok && nmi_seen) |=> nmi_ack_out && !int_ack_out)
		else $error("maskable served ahead of nonmaskable");

	chk_xlate_delay: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		vec_req |=> xl_valid ##1 vector_valid_out)
		else $error("vector translation latency wrong");

	chk_gap_set: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		s_ack_finish |=> gap)
		else $error("instruction gap not armed after acknowledge");

	chk_enable_end: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(seq_in.instr_end && seq_in.enable_irq_instruction) |-> !take_nmi && !take_int)
		else $error("acknowledge started at enable instruction end");

	chk_sample_only: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(!seq_in.sample_point && !take_nmi && !take_int)
		|=> $stable(nmi_seen) && $stable(int_seen))
		else $error("request view changed outside sample point");

	chk_stop_release: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(bus_in.dma_enable_write && !(take_nmi && bus_in.dma_active)) |=> !dma_stop_out)
		else $error("transfer stop not released by enable write");

	chk_stop_cause: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(!dma_stop_out && !(take_nmi && bus_in.dma_active)) |=> !dma_stop_out)
		else $error("transfer stopped without nonmaskable accept");

	chk_ack_exclusive: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		!(nmi_ack_out && int_ack_out))
		else $error("both acknowledges running at once");

	chk_page_offset: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		vector_valid_out |-> vector_addr_out[PAGE_LSB-1:0] == PAGE_LSB'($past(vec_log, 2)))
		else $error("vector offset bits altered by translation");
endmodule
`default_nettype wire

/* tb/far_side_model.sv */
// Request sources, transfer controller and refresh status as seen by the block
`timescale 1ns/1ps
`default_nettype none
module far_side_model
	import irq_accept_pkg::*;
(
	input  wire logic                  nmi_req_in,       // Nonmaskable request wanted
	input  wire logic [EXT_N-1:0]      ext_lvl_in,       // External maskable wanted
	input  wire logic [INTERNAL_N-1:0] int_lvl_in,       // Peripheral requests wanted
	input  wire logic                  refresh_in,       // Refresh cycle running
	input  wire logic                  dma_in,           // Transfer running
	input  wire logic                  burst_in,         // Burst memory-to-memory mode
	input  wire logic                  enwr_in,          // Channel enable rewritten
	input  wire logic [15:0]           vec_in,           // Vector page and byte
	output logic                       nmi_n_out,        // Nonmaskable pin
	output logic      [EXT_N-1:0]      ext_req_n_out,    // Maskable pins
	output logic      [INTERNAL_N-1:0] internal_req_out, // Peripheral lines
	output bus_status_t                bus_out,          // Bus status
	output logic      [7:0]            vector_byte_out,  // Vector low byte
	output logic      [7:0]            vector_page_out   // Vector high byte
);
	// Pins are active low, peripheral lines active high
	assign nmi_n_out = ~nmi_req_in;
	assign ext_req_n_out = ~ext_lvl_in;
	assign internal_req_out = int_lvl_in;
	// Only software rewriting the enable bit restarts a stopped channel
	assign bus_out = bus_status_t'({refresh_in, dma_in, burst_in, enwr_in});
	// Low bit left as given; odd values exercise the unforced bit
	assign vector_byte_out = vec_in[7:0];
	assign vector_page_out = vec_in[15:8];
endmodule
`default_nettype wire

/* tb/tb_cpu_interrupt_acceptance.sv */
// Self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_acceptance;
	import irq_accept_pkg::*;
	logic ref_clk_in = 0, srst_in = 1, nmi_req = 0, rf = 0, dma = 0, burst = 0, enwr = 0;
	logic [2:0] ext_lvl = 0;
	logic [5:0] int_lvl = 0;
	logic [15:0] vec = 0;
	seq_status_t seq = '0;
	xlate_cfg_t cfg = '0;
	logic nmi_n, nack, iack, stop, vvalid, pn = 0, pi = 0, nmi_in_ack = 0;
	logic [2:0] ext_n;
	logic [5:0] int_req;
	bus_status_t bus;
	logic [7:0] vb, vp;
	logic [19:0] vaddr;
	logic [1:0] q_code[$];
	logic [19:0] q_vec[$];
	int num_errors = 0, checks = 0, seed = 32'hdef26349;
	always #2.5 ref_clk_in = ~ref_clk_in;
	far_side_model u_far (.nmi_req_in(nmi_req), .ext_lvl_in(ext_lvl), .int_lvl_in(int_lvl),
		.refresh_in(rf), .dma_in(dma), .burst_in(burst), .enwr_in(enwr), .vec_in(vec),
		.nmi_n_out(nmi_n), .ext_req_n_out(ext_n), .internal_req_out(int_req), .bus_out(bus),
		.vector_byte_out(vb), .vector_page_out(vp));
	cpu_interrupt_acceptance u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.nmi_n_in(nmi_n), .ext_req_n_in(ext_n), .internal_req_in(int_req), .seq_in(seq),
		.bus_in(bus), .vector_byte_in(vb), .vector_page_in(vp), .xlate_cfg_in(cfg),
		.nmi_ack_out(nack), .int_ack_out(iack), .dma_stop_out(stop),
		.vector_valid_out(vvalid), .vector_addr_out(vaddr));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Expected translation: common area 1 outranks bank area
	function automatic logic [19:0] xl(input logic [15:0] a, input xlate_cfg_t c);
		logic [7:0] b;
		b = (a[15:12] >= c.common1_start) ? c.common1_base :
			(a[15:12] >= c.bank_start) ? c.bank_base : 8'h00;
		return {4'h0, a} + {b, 12'h000};
	endfunction
	task automatic nmi_pulse();
		nmi_req = 1;
		repeat (3) @(negedge ref_clk_in);
		nmi_req = 0;
	endtask
	// One instruction; op bit 0 enable, bit 1 disable; exp 0 none, 1 nonmaskable, 2 maskable
	task automatic instr(input logic [1:0] op, input logic rfr, input logic [1:0] exp);
		int n;
		rf = rfr;
		repeat (4) @(negedge ref_clk_in);
		seq.sample_point = 1;
		@(negedge ref_clk_in);
		seq.sample_point = 0;
		rf = 0;
		@(negedge ref_clk_in);
		seq.instr_end = 1;
		seq.enable_irq_instruction = op[0];
		seq.disable_irq_instruction = op[1];
		if (exp != 0) q_code.push_back(exp);
		if (exp == 2 && seq.vec_mode2) q_vec.push_back(xl(vec, cfg));
		@(negedge ref_clk_in);
		seq.instr_end = 0;
		seq.enable_irq_instruction = 0;
		seq.disable_irq_instruction = 0;
		if (exp != 0) begin
			n = 0;
			while (!(nack === 1 || iack === 1) && n < 10) begin
				@(negedge ref_clk_in);
				n++;
			end
			if (nmi_in_ack) nmi_pulse();
			repeat (2) @(negedge ref_clk_in);
			seq.ack_done = 1;
			@(negedge ref_clk_in);
			seq.ack_done = 0;
			if (exp == 2) begin
				ext_lvl = 0;
				int_lvl = 0;
			end
		end
	endtask
	// Watcher: every new acknowledge or vector consumes the oldest note
	always @(posedge ref_clk_in) begin
		if (!srst_in && ((nack && !pn) || (iack && !pi))) begin
			if (q_code.size() == 0) check("spurious_ack", {iack, nack}, 0);
			else check("ack_kind", {iack, nack}, q_code.pop_front());
		end
		if (!srst_in && vvalid === 1) begin
			if (q_vec.size() == 0) check("spurious_vec", 1, 0);
			else check("vector_addr", vaddr, q_vec.pop_front());
		end
		pn <= nack;
		pi <= iack;
	end
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge ref_clk_in);
		srst_in = 0;
		seq.irq_enable = 1;
		seq.vec_mode2 = 1;
		for (int i = 0; i < 9; i++) begin
			cfg = xlate_cfg_t'(24'($random(seed)));
			vec = 16'($random(seed));
			if (i < 3) ext_lvl[i] = 1;
			else int_lvl[i-3] = 1;
			instr(0, 0, 2);
		end
		$display("test sources done");
		seq.irq_enable = 0;
		int_lvl[5] = 1;
		instr(0, 0, 0);
		seq.irq_enable = 1;
		instr(0, 0, 2);
		ext_lvl[0] = 1;
		instr(1, 0, 0);
		instr(0, 0, 2);
		seq.vec_mode2 = 0;
		ext_lvl[1] = 1;
		instr(0, 0, 2);
		seq.vec_mode2 = 1;
		$display("test enable done");
		nmi_pulse();
		instr(0, 1, 0);
		instr(0, 0, 1);
		ext_lvl[1] = 1;
		instr(0, 1, 0);
		instr(0, 0, 2);
		$display("test refresh done");
		dma = 1;
		burst = 1;
		ext_lvl[2] = 1;
		instr(0, 0, 0);
		burst = 0;
		instr(0, 0, 2);
		nmi_pulse();
		instr(0, 0, 1);
		check("dma_stop", stop, 1);
		dma = 0;
		repeat (3) @(negedge ref_clk_in);
		check("dma_stop_held", stop, 1);
		enwr = 1;
		@(negedge ref_clk_in);
		enwr = 0;
		@(negedge ref_clk_in);
		check("dma_restart", stop, 0);
		$display("test dma done");
		ext_lvl[2] = 1;
		nmi_pulse();
		instr(0, 0, 1);
		instr(0, 0, 2);
		ext_lvl[0] = 1;
		nmi_in_ack = 1;
		instr(0, 0, 2);
		nmi_in_ack = 0;
		instr(0, 0, 1);
		ext_lvl[1] = 1;
		instr(2, 0, 0);
		instr(0, 0, 2);
		repeat (5) @(negedge ref_clk_in);
		check("notes_left", q_code.size() + q_vec.size(), 0);
		$display("test ordering done");
		summarize();
	end
endmodule
`default_nettype wire
